/* File: hdl/gpcs_pkg.sv */
// shared constants and carrier types for the gigabit pcs block
// assumes one 250 MHz system clock and an external 8b10b coder
package gpcs_pkg;
  // code groups as 8-bit values
  localparam logic [7:0] CG_COMMA = 8'hBC;
  localparam logic [7:0] CG_SOP = 8'hFB;
  localparam logic [7:0] CG_EOP = 8'hFD;
  localparam logic [7:0] CG_EXT = 8'hF7;
  localparam logic [7:0] CG_ERR = 8'hFE;
  localparam logic [7:0] CG_IDLE2 = 8'h50;
  localparam logic [7:0] CG_CFG1 = 8'hB5;
  localparam logic [7:0] CG_CFG2 = 8'h42;
  localparam logic [7:0] GMII_EXT_BYTE = 8'h0F;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int LINK_TIMER_NS = 10_000_000;
  localparam int LOSS_RESTART_NS = 1_000_000;
  localparam int LINK_TIMER_CYC = LINK_TIMER_NS / CLK_PERIOD_NS;
  localparam int LOSS_RESTART_CYC = LOSS_RESTART_NS / CLK_PERIOD_NS;
  // sync thresholds
  localparam logic [2:0] SYNC_ACQ_COMMAS = 3'h3;
  localparam logic [2:0] SYNC_LOSS_BAD = 3'h4;
  // ability word fields
  localparam int ABIL_ACK_BIT = 14;
  localparam int ABIL_FD_BIT = 5;
  localparam int ABIL_PAUSE_BIT = 7;
  localparam logic [1:0] ABIL_MATCH_CNT = 2'h3;
  localparam logic [15:0] ABIL_RESET = 16'h0000;

  typedef struct packed {
    logic k;
    logic [7:0] d;
  } gpcs_cg_t;
endpackage

/* File: hdl/gpcs_sync.sv */
// code-group alignment tracker and loss-of-alignment restart timer
// assumes decoded groups and error flags arrive registered on sys_clk
`timescale 1ns/1ps
module gpcs_sync import gpcs_pkg::*; #(
  parameter int LOSS_CYC = LOSS_RESTART_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // incoming groups
  input gpcs_cg_t cg_in,
  input wire logic code_err,
  input wire logic signal_detect,
  // aligned groups out
  output gpcs_cg_t cg_out,
  output logic cg_valid,
  output logic sync_ok,
  output logic restart
);
  typedef enum logic [2:0] {
    SY_LOSS = 3'b001,
    SY_ACQ = 3'b010,
    SY_OK = 3'b100
  } gpcs_sy_t;

  gpcs_sy_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [31:0] lost_q, lost_d;
  logic restart_q, restart_d;
  logic comma;

  assign comma = cg_in.k && (cg_in.d == CG_COMMA);

  // alignment state, comma and bad-group counting
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      SY_LOSS: begin
        cnt_d = 3'h0;
        if (comma && !code_err) begin
          st_d = SY_ACQ;
          cnt_d = 3'h1;
        end
      end
      SY_ACQ: begin
        if (code_err) begin
          st_d = SY_LOSS;
        end else if (comma) begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == SYNC_ACQ_COMMAS - 3'h1) begin
            st_d = SY_OK;
            cnt_d = 3'h0;
          end
        end
      end
      SY_OK: begin
        if (code_err) begin
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == SYNC_LOSS_BAD - 3'h1) begin
            st_d = SY_LOSS;
          end
        end else begin
          cnt_d = 3'h0;
        end
      end
    endcase
    if (!signal_detect) begin
      st_d = SY_LOSS;
    end
    // long loss of alignment asks negotiation to start again
    lost_d = (st_q == SY_OK) ? 32'h0 : lost_q + 32'h1;
    restart_d = 1'b0;
    if (lost_q == 32'(LOSS_CYC - 1)) begin
      restart_d = 1'b1;
      lost_d = 32'h0;
    end
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= SY_LOSS;
      cnt_q <= 3'h0;
      lost_q <= 32'h0;
      restart_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lost_q <= lost_d;
      restart_q <= restart_d;
    end
  end

  assign cg_out = cg_in;
  assign cg_valid = (st_q == SY_OK) && !code_err;
  assign sync_ok = (st_q == SY_OK);
  assign restart = restart_q;
endmodule

/* File: hdl/gpcs_top.sv */
// gigabit pcs: transmit coding, receive decoding, alignment and negotiation
// assumes a mac on the gmii side and a serdes doing 8b10b on the group side
`timescale 1ns/1ps
module gpcs_top import gpcs_pkg::*; #(
  parameter int LINK_CYC = LINK_TIMER_CYC,
  parameter int LOSS_CYC = LOSS_RESTART_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // gmii transmit from mac
  input wire logic [7:0] tx_d,
  input wire logic tx_en,
  input wire logic tx_er,
  // gmii receive to mac
  output logic [7:0] rx_d,
  output logic rx_dv,
  output logic rx_er,
  // code groups to serdes
  output logic [7:0] tx_data,
  output logic tx_kcntl,
  output logic correct_disp,
  output logic xmit_autoneg,
  // code groups from serdes
  input wire logic [7:0] rx_data,
  input wire logic rx_kcntl,
  input wire logic rx_cv_err,
  input wire logic rx_disp_err,
  input wire logic signal_detect,
  // management
  input wire logic [15:0] adv_ability,
  input wire logic negotiation_enable,
  output logic [15:0] lp_adv_ability,
  output logic page_received,
  output logic an_complete,
  output logic full_duplex,
  output logic pause_agreed,
  output logic sync_status
);
  if (LINK_CYC < 2 || LOSS_CYC < 2) begin : g_chk
    $error("timer counts must be at least 2");
  end

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_DATA = 4'b0010,
    TX_END = 4'b0100,
    TX_CFG = 4'b1000
  } gpcs_tx_t;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_COMMA = 5'b00010,
    RX_CFG_LO = 5'b00100,
    RX_CFG_HI = 5'b01000,
    RX_DATA = 5'b10000
  } gpcs_rx_t;
  typedef enum logic [5:0] {
    AN_OFF = 6'b000001,
    AN_RESTART = 6'b000010,
    AN_ABIL = 6'b000100,
    AN_ACK = 6'b001000,
    AN_DONE = 6'b010000,
    AN_LINK = 6'b100000
  } gpcs_an_t;

  // ---- transmit ----
  gpcs_tx_t tx_q, tx_d_st;
  logic [1:0] ph_q, ph_d;
  logic alt_q, alt_d;
  gpcs_cg_t txo_q, txo_d;
  logic disp_q, disp_d;
  logic send_cfg_q;
  logic [15:0] cfg_word_q;

  // transmit group selection from gmii byte and negotiation demand
  always_comb begin
    tx_d_st = tx_q;
    ph_d = ph_q + 2'h1;
    alt_d = alt_q;
    txo_d = '{k: 1'b1, d: CG_COMMA};
    disp_d = 1'b0;
    unique case (tx_q)
      TX_IDLE: begin
        ph_d = {1'b0, ~ph_q[0]};
        disp_d = 1'b1;
        if (ph_q[0]) begin
          txo_d = '{k: 1'b0, d: CG_IDLE2};
        end
        if (send_cfg_q && ph_q[0]) begin
          tx_d_st = TX_CFG;
          ph_d = 2'h0;
        end else if (tx_en && !send_cfg_q) begin
          txo_d = '{k: 1'b1, d: CG_SOP};
          disp_d = 1'b0;
          tx_d_st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_en) begin
          txo_d = tx_er ? '{k: 1'b1, d: CG_ERR} : '{k: 1'b0, d: tx_d};
        end else begin
          txo_d = '{k: 1'b1, d: CG_EOP};
          tx_d_st = TX_END;
        end
      end
      TX_END: begin
        txo_d = '{k: 1'b1, d: CG_EXT};
        if (!(tx_er && !tx_en)) begin
          tx_d_st = TX_IDLE; // extension ends when tx_er drops
          ph_d = 2'h0;
        end
      end
      TX_CFG: begin
        unique case (ph_q)
          2'h0: txo_d = '{k: 1'b1, d: CG_COMMA};
          2'h1: txo_d = '{k: 1'b0, d: alt_q ? CG_CFG2 : CG_CFG1};
          2'h2: txo_d = '{k: 1'b0, d: cfg_word_q[7:0]};
          2'h3: txo_d = '{k: 1'b0, d: cfg_word_q[15:8]};
        endcase
        if (ph_q == 2'h3) begin
          alt_d = ~alt_q;
          if (!send_cfg_q) begin
            tx_d_st = TX_IDLE;
          end
        end
      end
    endcase
  end

  // transmit registers launch each group on the clock edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_q <= TX_IDLE;
      ph_q <= 2'h0;
      alt_q <= 1'b0;
      txo_q <= '{k: 1'b1, d: CG_COMMA};
      disp_q <= 1'b0;
    end else begin
      tx_q <= tx_d_st;
      ph_q <= ph_d;
      alt_q <= alt_d;
      txo_q <= txo_d;
      disp_q <= disp_d;
    end
  end

  // ---- receive ----
  gpcs_cg_t rin_q;
  logic rerr_q;
  gpcs_cg_t fwd;
  logic fwd_ok, sync_w, restart_w;

  // input capture stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rin_q <= '{k: 1'b0, d: 8'h00};
      rerr_q <= 1'b0;
    end else begin
      rin_q <= '{k: rx_kcntl, d: rx_data};
      rerr_q <= rx_cv_err | rx_disp_err;
    end
  end

  gpcs_sync #(.LOSS_CYC(LOSS_CYC)) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .cg_in(rin_q),
    .code_err(rerr_q),
    .signal_detect(signal_detect),
    .cg_out(fwd),
    .cg_valid(fwd_ok),
    .sync_ok(sync_w),
    .restart(restart_w)
  );

  gpcs_rx_t rx_q, rx_d_st;
  logic [7:0] rxd_q, rxd_d;
  logic dv_q, dv_d, er_q, er_d, sync_q;
  logic [7:0] cfg_lo_q, cfg_lo_d;
  logic [15:0] rcfg_q, rcfg_d;
  logic rstb_q, rstb_d;

  // frame and configuration decoding of aligned groups
  always_comb begin
    rx_d_st = rx_q;
    rxd_d = 8'h00;
    dv_d = 1'b0;
    er_d = 1'b0;
    cfg_lo_d = cfg_lo_q;
    rcfg_d = rcfg_q;
    rstb_d = 1'b0;
    if (!fwd_ok && rx_q != RX_DATA) begin
      rx_d_st = RX_IDLE;
    end else begin
      unique case (rx_q)
        RX_IDLE, RX_COMMA: begin
          if (fwd.k && fwd.d == CG_SOP) begin
            rx_d_st = RX_DATA;
          end else if (fwd.k && fwd.d == CG_COMMA) begin
            rx_d_st = RX_COMMA;
          end else if (fwd.k && fwd.d == CG_EXT) begin
            rxd_d = GMII_EXT_BYTE;
            er_d = 1'b1;
            rx_d_st = RX_IDLE;
          end else if (rx_q == RX_COMMA && (fwd.d == CG_CFG1 || fwd.d == CG_CFG2)) begin
            rx_d_st = RX_CFG_LO;
          end else begin
            rx_d_st = RX_IDLE;
          end
        end
        RX_CFG_LO: begin
          cfg_lo_d = fwd.d;
          rx_d_st = RX_CFG_HI;
        end
        RX_CFG_HI: begin
          rcfg_d = {fwd.d, cfg_lo_q};
          rstb_d = 1'b1;
          rx_d_st = RX_IDLE;
        end
        RX_DATA: begin
          if (!fwd_ok) begin
            rxd_d = fwd.d; // code error or alignment loss inside a frame
            dv_d = 1'b1;
            er_d = 1'b1;
            rx_d_st = RX_IDLE;
          end else if (fwd.k && fwd.d == CG_EOP) begin
            rx_d_st = RX_IDLE;
          end else if (fwd.k) begin
            rxd_d = fwd.d;
            dv_d = 1'b1;
            er_d = 1'b1;
          end else begin
            rxd_d = fwd.d;
            dv_d = 1'b1;
          end
        end
      endcase
    end
  end

  // receive registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_q <= RX_IDLE;
      rxd_q <= 8'h00;
      dv_q <= 1'b0;
      er_q <= 1'b0;
      cfg_lo_q <= 8'h00;
      rcfg_q <= 16'h0000;
      rstb_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      rx_q <= rx_d_st;
      rxd_q <= rxd_d;
      dv_q <= dv_d;
      er_q <= er_d;
      cfg_lo_q <= cfg_lo_d;
      rcfg_q <= rcfg_d;
      rstb_q <= rstb_d;
      sync_q <= sync_w;
    end
  end

  // ---- auto-negotiation ----
  gpcs_an_t an_q, an_d;
  logic [31:0] tmr_q, tmr_d;
  logic [1:0] mcnt_q, mcnt_d;
  logic [15:0] last_q, last_d, lp_q, lp_d, cw_d;
  logic page_q, page_d, done_q, done_d, fd_q, fd_d, pz_q, pz_d, act_q, act_d, scfg_d;
  logic [15:0] ack_mask;

  assign ack_mask = ~(16'h1 << ABIL_ACK_BIT);

  // link configuration exchange with the partner
  always_comb begin
    an_d = an_q;
    tmr_d = tmr_q + 32'h1;
    mcnt_d = mcnt_q;
    last_d = last_q;
    lp_d = lp_q;
    page_d = page_q;
    done_d = 1'b0;
    unique case (an_q)
      AN_OFF: begin
        if (negotiation_enable) begin
          an_d = AN_RESTART;
          tmr_d = 32'h0;
        end
      end
      AN_RESTART: begin
        page_d = 1'b0;
        mcnt_d = 2'h0;
        if (tmr_q == 32'(LINK_CYC - 1)) begin
          an_d = AN_ABIL;
        end
      end
      AN_ABIL: begin
        // a zero word restarts only once matched, so one stale restart word is harmless
        if (rstb_q) begin
          last_d = rcfg_q & ack_mask;
          mcnt_d = ((rcfg_q & ack_mask) == last_q) ? mcnt_q + 2'h1 : 2'h0;
          if ((rcfg_q & ack_mask) == last_q && mcnt_q == ABIL_MATCH_CNT - 2'h1) begin
            if (rcfg_q == 16'h0000) begin
              an_d = AN_RESTART;
              tmr_d = 32'h0;
            end else begin
              lp_d = rcfg_q;
              page_d = 1'b1;
              an_d = AN_ACK;
            end
          end
        end
      end
      AN_ACK: begin
        if (rstb_q && rcfg_q[ABIL_ACK_BIT] && (rcfg_q & ack_mask) == (lp_q & ack_mask)) begin
          lp_d = rcfg_q;
          an_d = AN_DONE;
          tmr_d = 32'h0;
        end
      end
      AN_DONE: begin
        mcnt_d = 2'h0;
        if (tmr_q == 32'(LINK_CYC - 1)) begin
          an_d = AN_LINK;
        end
      end
      AN_LINK: begin
        done_d = 1'b1;
        // words still in flight from the last sets must not restart the link
        if (rstb_q) begin
          mcnt_d = mcnt_q + 2'h1;
          if (mcnt_q == ABIL_MATCH_CNT - 2'h1) begin
            an_d = AN_RESTART; // partner restarted
            tmr_d = 32'h0;
          end
        end
      end
    endcase
    if (an_q == AN_ACK && rstb_q && rcfg_q == 16'h0000) begin
      an_d = AN_RESTART;
      tmr_d = 32'h0;
    end
    if (restart_w && an_q != AN_OFF) begin
      an_d = AN_RESTART;
      tmr_d = 32'h0;
    end
    if (!negotiation_enable) begin
      an_d = AN_OFF;
      page_d = 1'b0;
      done_d = 1'b0;
    end
    act_d = (an_d != AN_OFF) && (an_d != AN_LINK);
    scfg_d = act_d;
    cw_d = (an_d == AN_RESTART) ? 16'h0000 : adv_ability;
    if (an_d == AN_ACK || an_d == AN_DONE) begin
      cw_d[ABIL_ACK_BIT] = 1'b1;
    end
    fd_d = adv_ability[ABIL_FD_BIT] & lp_d[ABIL_FD_BIT];
    pz_d = adv_ability[ABIL_PAUSE_BIT] & lp_d[ABIL_PAUSE_BIT];
  end

  // negotiation registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      an_q <= AN_OFF;
      tmr_q <= 32'h0;
      mcnt_q <= 2'h0;
      last_q <= ABIL_RESET;
      lp_q <= ABIL_RESET;
      page_q <= 1'b0;
      done_q <= 1'b0;
      fd_q <= 1'b0;
      pz_q <= 1'b0;
      act_q <= 1'b0;
      send_cfg_q <= 1'b0;
      cfg_word_q <= 16'h0000;
    end else begin
      an_q <= an_d;
      tmr_q <= tmr_d;
      mcnt_q <= mcnt_d;
      last_q <= last_d;
      lp_q <= lp_d;
      page_q <= page_d;
      done_q <= done_d;
      fd_q <= fd_d;
      pz_q <= pz_d;
      act_q <= act_d;
      send_cfg_q <= scfg_d;
      cfg_word_q <= cw_d;
    end
  end

  // outputs straight from registers
  assign tx_data = txo_q.d;
  assign tx_kcntl = txo_q.k;
  assign correct_disp = disp_q;
  assign xmit_autoneg = act_q;
  assign rx_d = rxd_q;
  assign rx_dv = dv_q;
  assign rx_er = er_q;
  assign lp_adv_ability = lp_q;
  assign page_received = page_q;
  assign an_complete = done_q;
  assign full_duplex = fd_q;
  assign pause_agreed = pz_q;
  assign sync_status = sync_q;
endmodule

/* File: tb/gpcs_top_asserts.sv */
// concurrent checks on the gigabit pcs top ports
// assumes one clock domain and a bind placed in the bench top
`timescale 1ns/1ps
module gpcs_top_chk import gpcs_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // gmii side
  input wire logic [7:0] tx_d,
  input wire logic tx_en,
  input wire logic tx_er,
  input wire logic [7:0] rx_d,
  input wire logic rx_dv,
  input wire logic rx_er,
  // group side
  input wire logic [7:0] tx_data,
  input wire logic tx_kcntl,
  input wire logic correct_disp,
  input wire logic xmit_autoneg,
  input wire logic [7:0] rx_data,
  input wire logic rx_kcntl,
  input wire logic signal_detect,
  // management
  input wire logic [15:0] adv_ability,
  input wire logic negotiation_enable,
  input wire logic [15:0] lp_adv_ability,
  input wire logic page_received,
  input wire logic an_complete,
  input wire logic full_duplex,
  input wire logic pause_agreed,
  input wire logic sync_status
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // end of frame: terminate then extend group
  sequence s_end;
    tx_data == CG_EOP && tx_kcntl ##1 tx_data == CG_EXT && tx_kcntl;
  endsequence
  // frame start seen from a settled idle
  sequence s_fresh;
    $rose(tx_en) && !tx_er && !xmit_autoneg && !$past(tx_en, 2) && !$past(tx_en, 3);
  endsequence
  a_start_group: assert property (s_fresh |=> tx_data == CG_SOP && tx_kcntl)
    else $error("start group missing");
  a_data_group: assert property (tx_en && $past(tx_en) && !tx_er && !xmit_autoneg
    |=> tx_data == $past(tx_d) && !tx_kcntl) else $error("data group wrong");
  a_err_group: assert property (tx_en && tx_er && $past(tx_en) && !xmit_autoneg
    |=> tx_data == CG_ERR && tx_kcntl) else $error("error group missing");
  a_frame_end: assert property ($fell(tx_en) && !tx_er && !xmit_autoneg |=> s_end)
    else $error("end sequence wrong");
  a_gap_disp: assert property (correct_disp |-> (tx_data == CG_COMMA && tx_kcntl)
    || (tx_data == CG_IDLE2 && !tx_kcntl)) else $error("disparity flag outside idle");
  a_rx_byte: assert property (rx_dv && !rx_er |-> rx_d == $past(rx_data, 2)
    && !$past(rx_kcntl, 2)) else $error("receive byte wrong");
  a_rx_extend: assert property (rx_er && !rx_dv |-> rx_d == GMII_EXT_BYTE)
    else $error("extension byte wrong");
  a_loss_sync: assert property ($fell(signal_detect) |-> ##[1:4] !sync_status)
    else $error("alignment kept on signal loss");
  a_an_gate: assert property (!negotiation_enable [*4] |-> !xmit_autoneg)
    else $error("negotiation active while disabled");
  a_an_result: assert property (an_complete |-> page_received
    && full_duplex == (adv_ability[ABIL_FD_BIT] & lp_adv_ability[ABIL_FD_BIT])
    && pause_agreed == (adv_ability[ABIL_PAUSE_BIT] & lp_adv_ability[ABIL_PAUSE_BIT]))
    else $error("negotiation result wrong");
endmodule

/* File: tb/gpcs_serdes_model.sv */
// serdes side model: returns each sent group as a decoded receive group
// assumes the bench raises line_bad to corrupt the line
`timescale 1ns/1ps
module gpcs_serdes_model import gpcs_pkg::*; (
  // clock
  input wire logic sys_clk,
  // groups from the block
  input wire logic [7:0] tx_data,
  input wire logic tx_kcntl,
  // line control
  input wire logic line_bad,
  // decoded groups to the block
  output logic [7:0] rx_data,
  output logic rx_kcntl,
  output logic rx_cv_err,
  output logic rx_disp_err
);
  gpcs_cg_t grp_q = '{k: 1'b1, d: CG_COMMA};
  logic bad_q = 1'b0;
  // one cycle of line delay; a bad line toggles data every cycle
  always @(posedge sys_clk) begin
    grp_q <= line_bad ? '{k: 1'b0, d: ~grp_q.d} : '{k: tx_kcntl, d: tx_data};
    bad_q <= line_bad;
  end
  assign rx_data = grp_q.d;
  assign rx_kcntl = grp_q.k;
  assign rx_cv_err = bad_q;
  assign rx_disp_err = bad_q;
endmodule

/* File: tb/test_gpcs_top.sv */
// bench for the gigabit pcs top with the serdes model looping groups back
// assumes short link and loss timers given through the top parameters
`timescale 1ns/1ps
module test_gpcs_top import gpcs_pkg::*;;
  localparam int LINK_N = 8;
  localparam int LOSS_N = 16;
  logic sys_clk = 1'b0, srst = 1'b1, tx_en = 1'b0, tx_er = 1'b0, line_bad = 1'b0;
  logic signal_detect = 1'b1, negotiation_enable = 1'b0, seen;
  logic [7:0] tx_d = 8'h00, rx_d, tx_data, rx_data;
  logic [15:0] adv_ability = 16'h01A0, lp_adv_ability;
  logic rx_dv, rx_er, tx_kcntl, correct_disp, xmit_autoneg, rx_kcntl, rx_cv_err, rx_disp_err;
  logic page_received, an_complete, full_duplex, pause_agreed, sync_status;
  logic [8:0] exp_q[$];
  logic [8:0] exp_b;
  logic [31:0] lfsr_q = 32'h7EEDA6FD;
  int errors = 0;
  int total_checks = 0;
  int i;
  // clock
  always #2 sys_clk = ~sys_clk;
  gpcs_top #(.LINK_CYC(LINK_N), .LOSS_CYC(LOSS_N)) uut (.sys_clk(sys_clk), .srst(srst),
    .tx_d(tx_d), .tx_en(tx_en), .tx_er(tx_er), .rx_d(rx_d), .rx_dv(rx_dv), .rx_er(rx_er),
    .tx_data(tx_data), .tx_kcntl(tx_kcntl), .correct_disp(correct_disp),
    .xmit_autoneg(xmit_autoneg), .rx_data(rx_data), .rx_kcntl(rx_kcntl),
    .rx_cv_err(rx_cv_err), .rx_disp_err(rx_disp_err), .signal_detect(signal_detect),
    .adv_ability(adv_ability), .negotiation_enable(negotiation_enable),
    .lp_adv_ability(lp_adv_ability), .page_received(page_received),
    .an_complete(an_complete), .full_duplex(full_duplex), .pause_agreed(pause_agreed),
    .sync_status(sync_status));
  gpcs_serdes_model line (.sys_clk(sys_clk), .tx_data(tx_data), .tx_kcntl(tx_kcntl),
    .line_bad(line_bad), .rx_data(rx_data), .rx_kcntl(rx_kcntl), .rx_cv_err(rx_cv_err),
    .rx_disp_err(rx_disp_err));
  // random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // mismatch report
  task automatic report(input logic [15:0] got, input logic [15:0] exp);
    errors++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  // compares per kind of result
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) report({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic chk_byte(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) report({7'h00, got}, {7'h00, exp});
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) report(got, exp);
  endtask
  // verdict
  task automatic close_out();
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one mac frame of random bytes, optional error byte and extension
  task automatic send_frame(input int n, input int err_at, input int ext);
    for (int b = 0; b < n; b++) begin
      lfsr_q = lfsr_next(lfsr_q);
      @(posedge sys_clk) #1;
      tx_en = 1'b1;
      tx_d = lfsr_q[7:0];
      tx_er = (b == err_at);
      if (b > 0) exp_q.push_back({tx_er, tx_d}); // first byte becomes the start group
    end
    @(posedge sys_clk) #1;
    tx_en = 1'b0;
    tx_er = (ext > 0);
    repeat (ext) @(posedge sys_clk);
    @(posedge sys_clk) #1;
    tx_er = 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  // takes the oldest expected byte whenever a frame byte appears
  always @(negedge sys_clk) begin
    if (rx_dv === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk_bit(rx_dv, 1'b0);
      end else begin
        exp_b = exp_q.pop_front();
        if (exp_b[8]) begin
          chk_bit(rx_er, 1'b1);
        end else begin
          chk_byte({rx_er, rx_d}, exp_b);
        end
      end
    end
  end
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    chk_byte({tx_kcntl, tx_data}, {1'b1, CG_COMMA});
    srst = 1'b0;
    for (i = 0; i < 100 && sync_status !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk_bit(sync_status, 1'b1);
    chk_bit(correct_disp, 1'b1);
    for (i = 0; i < 3; i++) send_frame(6 + i * 4, (i == 1) ? 3 : -1, i);
    repeat (10) @(posedge sys_clk);
    chk_word(16'(exp_q.size()), 16'h0000);
    #1;
    negotiation_enable = 1'b1;
    seen = 1'b0;
    for (i = 0; i < 400 && an_complete !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
      seen = seen | xmit_autoneg;
    end
    chk_bit(seen, 1'b1);
    chk_bit(an_complete, 1'b1);
    chk_word(lp_adv_ability, adv_ability | (16'h0001 << ABIL_ACK_BIT));
    chk_word({full_duplex, pause_agreed, xmit_autoneg}, 16'h0006);
    line_bad = 1'b1;
    for (i = 0; i < LOSS_N + 40 && xmit_autoneg !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk_bit(xmit_autoneg, 1'b1);
    chk_bit(sync_status, 1'b0);
    line_bad = 1'b0;
    repeat (40) @(posedge sys_clk);
    #1;
    signal_detect = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk_bit(sync_status, 1'b0);
    signal_detect = 1'b1;
    negotiation_enable = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk_bit(xmit_autoneg, 1'b0);
    close_out();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    close_out();
  end
endmodule
bind gpcs_top gpcs_top_chk chk (.sys_clk(sys_clk), .srst(srst), .tx_d(tx_d), .tx_en(tx_en),
  .tx_er(tx_er), .rx_d(rx_d), .rx_dv(rx_dv), .rx_er(rx_er), .tx_data(tx_data),
  .tx_kcntl(tx_kcntl), .correct_disp(correct_disp), .xmit_autoneg(xmit_autoneg),
  .rx_data(rx_data), .rx_kcntl(rx_kcntl), .signal_detect(signal_detect),
  .adv_ability(adv_ability), .negotiation_enable(negotiation_enable),
  .lp_adv_ability(lp_adv_ability), .page_received(page_received),
  .an_complete(an_complete), .full_duplex(full_duplex), .pause_agreed(pause_agreed),
  .sync_status(sync_status));
